/* File: hdl/dhs_defs.svh */
// constants for the converter host signalling block
`ifndef DHS_DEFS_SVH
`define DHS_DEFS_SVH
`define DHS_NUM_INT 8
`define DHS_NUM_CHAN 8
`define DHS_CHAN_W 3
`define DHS_FIFO_DEPTH 32
`define DHS_CNT_W 6
`define DHS_SYNC_W 3
`define DHS_SYNC_BIT_TRIG 0
`define DHS_SYNC_BIT_BW 1
`define DHS_SYNC_BIT_CS 2
`define DHS_RST_STATUS 8'h00
`define DHS_RST_TRIG_DIR 1'b0
`endif

/* File: hdl/dhs_pkg.sv */
// types for the converter host signalling block
package dhs_pkg;
    typedef enum logic [1:0] {
        DHS_IDLE,
        DHS_ARMED,
        DHS_BUSY
    } dhs_state_type;
endpackage

/* File: hdl/dhs_sync.sv */
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module dhs_sync #(
    parameter int WIDTH = 3
) (
    input wire logic CLK_SYS_IN,
    input wire logic RESET_IN,
    input wire logic [WIDTH-1:0] RESET_VAL_IN,
    input wire logic [WIDTH-1:0] ASYNC_IN,
    output logic [WIDTH-1:0] SYNC_OUT
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] stable_r;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
                if (RESET_IN) begin
                    meta_r[i] <= 1'b0;
                    stable_r[i] <= 1'b0;
                end else begin
                    meta_r[i] <= ASYNC_IN[i];
                    stable_r[i] <= meta_r[i];
                end
            end
        end
    endgenerate

    assign SYNC_OUT = stable_r;
endmodule
`default_nettype wire

/* File: hdl/dhs_top.sv */
// host-facing control pins of the data acquisition converter
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
`include "dhs_defs.svh"
module dhs_top
    import dhs_pkg::*;
#(
    parameter int NUM_INT = `DHS_NUM_INT,
    parameter int NUM_CHAN = `DHS_NUM_CHAN,
    parameter int CHAN_W = `DHS_CHAN_W,
    parameter int CNT_W = `DHS_CNT_W
) (
    input wire logic CLK_SYS_IN,
    input wire logic RESET_IN,
    input wire logic TRIG_DIR_SELECT_IN,
    input wire logic SAMPLE_TRIGGER_PIN_IN,
    output logic SAMPLE_TRIGGER_PIN_OUT,
    output logic SAMPLE_TRIGGER_PIN_OE_N_OUT,
    input wire logic SEQ_START_IN,
    input wire logic INSTR_IS_COMPARE_IN,
    input wire logic OP_DONE_IN,
    output logic SAMPLE_HOLD_OUT,
    output logic START_CONVERT_OUT,
    output logic START_COMPARE_OUT,
    output logic OP_BUSY_OUT,
    input wire logic CHIP_SEL_N_IN,
    output logic CLOCK_RUN_OUT,
    input wire logic BUS_WIDTH_SELECT_IN,
    input wire logic HOST_READ_EN_IN,
    output logic BYTE_MODE_OUT,
    output logic DATA_LO_OE_N_OUT,
    output logic DATA_HI_OE_N_OUT,
    input wire logic [NUM_INT-1:0] INT_EVENT_IN,
    input wire logic [NUM_INT-1:0] INT_ENABLE_IN,
    input wire logic INT_STATUS_READ_IN,
    output logic [NUM_INT-1:0] INT_STATUS_OUT,
    output logic IRQ_OUT_N,
    input wire logic [CNT_W-1:0] FIFO_COUNT_IN,
    input wire logic [CNT_W-1:0] XFER_THRESHOLD_IN,
    output logic TRANSFER_REQUEST_OUT,
    input wire logic INSTR_DIFF_IN,
    input wire logic [CHAN_W-1:0] INSTR_CHAN_POS_IN,
    input wire logic [CHAN_W-1:0] INSTR_CHAN_NEG_IN,
    output logic [NUM_CHAN-1:0] MUX_POS_SEL_OUT,
    output logic [NUM_CHAN-1:0] MUX_NEG_SEL_OUT
);
    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [`DHS_SYNC_W-1:0] pins_sync;
    logic trig_prev_r;
    logic trig_in;
    logic run;

    dhs_sync #(
        .WIDTH(`DHS_SYNC_W)
    ) u_sync (
        .CLK_SYS_IN(CLK_SYS_IN),
        .RESET_IN(RESET_IN),
        .RESET_VAL_IN('0),
        .ASYNC_IN({CHIP_SEL_N_IN, BUS_WIDTH_SELECT_IN, SAMPLE_TRIGGER_PIN_IN}),
        .SYNC_OUT(pins_sync)
    );

    assign trig_in = pins_sync[`DHS_SYNC_BIT_TRIG];
    assign run = pins_sync[`DHS_SYNC_BIT_CS];

    function automatic logic [NUM_CHAN-1:0] chan_onehot(input logic [CHAN_W-1:0] ch);
        logic [NUM_CHAN-1:0] v;
        v = '0;
        v[ch] = 1'b1;
        return v;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // trigger direction
    logic trig_dir_r;

    always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            trig_dir_r <= `DHS_RST_TRIG_DIR;
            SAMPLE_TRIGGER_PIN_OE_N_OUT <= 1'b1;
        end else begin
            trig_dir_r <= TRIG_DIR_SELECT_IN;
            SAMPLE_TRIGGER_PIN_OE_N_OUT <= ~TRIG_DIR_SELECT_IN;
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            trig_prev_r <= 1'b0;
        end else begin
            trig_prev_r <= trig_in;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // operation sequencing
    dhs_state_type state_r;
    dhs_state_type state_nxt;
    logic trig_edge;
    logic start_go;

    assign trig_edge = ~trig_dir_r & trig_in & ~trig_prev_r;

    always_comb begin
        state_nxt = state_r;
        start_go = 1'b0;
        case (state_r)
            DHS_IDLE: begin
                if (trig_edge) begin
                    state_nxt = DHS_ARMED;
                end else if (trig_dir_r && SEQ_START_IN && run) begin
                    state_nxt = DHS_BUSY;
                    start_go = 1'b1;
                end
            end
            DHS_ARMED: begin
                if (run) begin
                    state_nxt = DHS_BUSY;
                    start_go = 1'b1;
                end
            end
            DHS_BUSY: begin
                if (OP_DONE_IN) begin
                    state_nxt = DHS_IDLE;
                end
            end
            default: begin
                state_nxt = DHS_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            state_r <= DHS_IDLE;
            SAMPLE_HOLD_OUT <= 1'b0;
            START_CONVERT_OUT <= 1'b0;
            START_COMPARE_OUT <= 1'b0;
            OP_BUSY_OUT <= 1'b0;
            SAMPLE_TRIGGER_PIN_OUT <= 1'b0;
            CLOCK_RUN_OUT <= 1'b0;
        end else begin
            state_r <= state_nxt;
            SAMPLE_HOLD_OUT <= trig_edge && state_r == DHS_IDLE;
            START_CONVERT_OUT <= start_go & ~INSTR_IS_COMPARE_IN;
            START_COMPARE_OUT <= start_go & INSTR_IS_COMPARE_IN;
            OP_BUSY_OUT <= state_nxt == DHS_BUSY;
            SAMPLE_TRIGGER_PIN_OUT <= state_nxt == DHS_BUSY;
            CLOCK_RUN_OUT <= run;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // channel selection latched at start
    always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            MUX_POS_SEL_OUT <= '0;
            MUX_NEG_SEL_OUT <= '0;
        end else if (start_go) begin
            MUX_POS_SEL_OUT <= chan_onehot(INSTR_CHAN_POS_IN);
            MUX_NEG_SEL_OUT <= INSTR_DIFF_IN ? chan_onehot(INSTR_CHAN_NEG_IN) : '0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // bus width and data lane enables
    always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            BYTE_MODE_OUT <= 1'b0;
            DATA_LO_OE_N_OUT <= 1'b1;
            DATA_HI_OE_N_OUT <= 1'b1;
        end else begin
            BYTE_MODE_OUT <= pins_sync[`DHS_SYNC_BIT_BW];
            DATA_LO_OE_N_OUT <= ~HOST_READ_EN_IN;
            DATA_HI_OE_N_OUT <= ~(HOST_READ_EN_IN & ~pins_sync[`DHS_SYNC_BIT_BW]);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // interrupt status
    logic [NUM_INT-1:0] status_nxt;

    always_comb begin
        status_nxt = (INT_STATUS_READ_IN ? '0 : INT_STATUS_OUT)
                     | (INT_EVENT_IN & INT_ENABLE_IN);
    end

    always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            INT_STATUS_OUT <= `DHS_RST_STATUS;
            IRQ_OUT_N <= 1'b1;
        end else begin
            INT_STATUS_OUT <= status_nxt;
            IRQ_OUT_N <= ~(|status_nxt);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // transfer request
    always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            TRANSFER_REQUEST_OUT <= 1'b0;
        end else if (FIFO_COUNT_IN == '0) begin
            TRANSFER_REQUEST_OUT <= 1'b0;
        end else if (FIFO_COUNT_IN == XFER_THRESHOLD_IN) begin
            TRANSFER_REQUEST_OUT <= 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (RESET_IN);

    AST_DIR_FOLLOWS: assert property (
        ##1 (SAMPLE_TRIGGER_PIN_OE_N_OUT == ~$past(TRIG_DIR_SELECT_IN)))
        else $error("trigger pin enable does not follow direction select");
    AST_EDGE_HOLD: assert property (
        (trig_edge && state_r == DHS_IDLE) |=> SAMPLE_HOLD_OUT)
        else $error("trigger edge did not freeze sample hold");
    AST_HOLD_START: assert property (
        (state_r == DHS_ARMED && run) |=> (START_CONVERT_OUT || START_COMPARE_OUT))
        else $error("no start after trigger");
    AST_START_KIND: assert property (
        start_go |=> (START_COMPARE_OUT == $past(INSTR_IS_COMPARE_IN))
        && (START_CONVERT_OUT != START_COMPARE_OUT))
        else $error("wrong operation started");
    AST_PIN_HIGH_BUSY: assert property (
        (START_CONVERT_OUT || START_COMPARE_OUT) |-> SAMPLE_TRIGGER_PIN_OUT && OP_BUSY_OUT)
        else $error("trigger output not high during operation");
    AST_PIN_LOW_DONE: assert property (
        (state_r == DHS_BUSY && OP_DONE_IN) |=> !SAMPLE_TRIGGER_PIN_OUT)
        else $error("trigger output not low after completion");
    AST_HI_LANE: assert property (
        BYTE_MODE_OUT && $past(BYTE_MODE_OUT) |-> ##0 DATA_HI_OE_N_OUT)
        else $error("upper data lines driven in byte mode");
    AST_IRQ_SET: assert property (
        |(INT_EVENT_IN & INT_ENABLE_IN) |=> !IRQ_OUT_N && (INT_STATUS_OUT != '0))
        else $error("unmasked event did not raise interrupt");
    AST_READ_CLEAR: assert property (
        (INT_STATUS_READ_IN && !(|(INT_EVENT_IN & INT_ENABLE_IN))) |=> IRQ_OUT_N
        && INT_STATUS_OUT == '0)
        else $error("status read did not clear interrupt");
    AST_MASKED: assert property (
        (INT_STATUS_OUT == '0 && !(|(INT_EVENT_IN & INT_ENABLE_IN))) |=> IRQ_OUT_N)
        else $error("interrupt without unmasked cause");
    AST_XFER_SET: assert property (
        (FIFO_COUNT_IN != '0 && FIFO_COUNT_IN == XFER_THRESHOLD_IN) |=> TRANSFER_REQUEST_OUT)
        else $error("transfer request not raised at threshold");
    AST_XFER_HOLD: assert property (
        (TRANSFER_REQUEST_OUT && FIFO_COUNT_IN != '0) |=> TRANSFER_REQUEST_OUT)
        else $error("transfer request dropped before empty");
    AST_XFER_CLR: assert property (
        (FIFO_COUNT_IN == '0) |=> !TRANSFER_REQUEST_OUT)
        else $error("transfer request not cleared when empty");
    AST_HALT: assert property (
        (state_r == DHS_ARMED && !run) |=> !START_CONVERT_OUT && !START_COMPARE_OUT)
        else $error("operation started while chip selected");
    AST_MUX_ONE: assert property (
        $onehot(MUX_POS_SEL_OUT) || MUX_POS_SEL_OUT == '0)
        else $error("more than one positive channel");

    COV_EXT_CONVERT: cover property (SAMPLE_HOLD_OUT ##[1:8] START_CONVERT_OUT);
    COV_COMPARE: cover property (START_COMPARE_OUT ##[1:20] !SAMPLE_TRIGGER_PIN_OUT);
    COV_IRQ_ACK: cover property (!IRQ_OUT_N ##[1:10] IRQ_OUT_N);
    COV_XFER: cover property (TRANSFER_REQUEST_OUT ##[1:40] !TRANSFER_REQUEST_OUT);
endmodule
`default_nettype wire

/* File: sim/dhs_host_model.sv */
// host processor model: acknowledges interrupts by a status read
`timescale 1ns/1ps
`default_nettype none
module dhs_host_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic irq_n_in,
    input wire logic ack_en_in,
    input wire logic [3:0] delay_in,
    output logic status_read_out,
    output logic chip_sel_n_out
);
//////////////////////////////////////////////////////////////////////////////
logic [3:0] wait_r;
always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
        wait_r <= 4'h0;
        status_read_out <= 1'b0;
        chip_sel_n_out <= 1'b1;
    end else begin
        status_read_out <= 1'b0;
        chip_sel_n_out <= 1'b1;
        if (ack_en_in && !irq_n_in && !status_read_out) begin
            if (wait_r >= delay_in) begin
                status_read_out <= 1'b1;
                chip_sel_n_out <= 1'b0;
                wait_r <= 4'h0;
            end else begin
                wait_r <= wait_r + 4'h1;
            end
        end else begin
            wait_r <= 4'h0;
        end
    end
end
endmodule
`default_nettype wire

/* File: sim/test_daq_host_signalling.sv */
// self-checking bench for the converter host signalling block
`timescale 1ns/1ps
`default_nettype none
module test_daq_host_signalling
    import dhs_pkg::*;
;
//////////////////////////////////////////////////////////////////////////////
logic clk = 0, rst = 1, dir = 0, pin = 0, seq = 0, cmp = 0, done = 0;
logic bcs_n = 1, bw = 0, rd = 0, ack = 0, diff = 0, irq_prev = 1;
logic [3:0] dly = 0;
logic [7:0] ev = 0, en = 0;
logic [5:0] cnt = 0, thr = 0;
logic [2:0] pos = 0, neg = 0;
logic sread, hcs_n, pin_o, oe_n, sh, stc, stp, busy, crun, bmode, lo_n, hi_n, irq_n, xreq;
logic [7:0] st, mp, mn;
int num_errors = 0, n_compared = 0, cyc = 0, n_starts = 0, i, k, t;
logic [16:0] op_q[$];
logic [7:0] irq_q[$];
always #2 clk = ~clk;
dhs_top DUT (.CLK_SYS_IN(clk), .RESET_IN(rst), .TRIG_DIR_SELECT_IN(dir),
    .SAMPLE_TRIGGER_PIN_IN(pin), .SAMPLE_TRIGGER_PIN_OUT(pin_o),
    .SAMPLE_TRIGGER_PIN_OE_N_OUT(oe_n), .SEQ_START_IN(seq), .INSTR_IS_COMPARE_IN(cmp),
    .OP_DONE_IN(done), .SAMPLE_HOLD_OUT(sh), .START_CONVERT_OUT(stc),
    .START_COMPARE_OUT(stp), .OP_BUSY_OUT(busy), .CHIP_SEL_N_IN(bcs_n & hcs_n),
    .CLOCK_RUN_OUT(crun), .BUS_WIDTH_SELECT_IN(bw), .HOST_READ_EN_IN(rd),
    .BYTE_MODE_OUT(bmode), .DATA_LO_OE_N_OUT(lo_n), .DATA_HI_OE_N_OUT(hi_n),
    .INT_EVENT_IN(ev), .INT_ENABLE_IN(en), .INT_STATUS_READ_IN(sread),
    .INT_STATUS_OUT(st), .IRQ_OUT_N(irq_n), .FIFO_COUNT_IN(cnt), .XFER_THRESHOLD_IN(thr),
    .TRANSFER_REQUEST_OUT(xreq), .INSTR_DIFF_IN(diff), .INSTR_CHAN_POS_IN(pos),
    .INSTR_CHAN_NEG_IN(neg), .MUX_POS_SEL_OUT(mp), .MUX_NEG_SEL_OUT(mn));
dhs_host_model HOST (.clk_in(clk), .rst_in(rst), .irq_n_in(irq_n), .ack_en_in(ack),
    .delay_in(dly), .status_read_out(sread), .chip_sel_n_out(hcs_n));
//////////////////////////////////////////////////////////////////////////////
task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
        num_errors++;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task end_of_test;
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
endtask
task settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
endtask
always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
        num_errors++;
        end_of_test;
    end
end
// monitor: oldest note is compared with each start or interrupt
always @(negedge clk) begin
    if (stc || stp) begin
        n_starts++;
        check({stp, mp, mn}, op_q.pop_front());
    end
    if (irq_prev && !irq_n) check(st, irq_q.pop_front());
    irq_prev = irq_n;
end
//////////////////////////////////////////////////////////////////////////////
task do_op(input logic d, c, df, h, input logic [2:0] p, q);
    int ns;
    @(posedge clk);
    {dir, cmp, diff, pos, neg, bcs_n} <= {d, c, df, p, q, !h};
    op_q.push_back({c, 8'h01 << p, df ? 8'h01 << q : 8'h00});
    ns = n_starts;
    settle(3);
    @(posedge clk);
    {seq, pin} <= {d, !d};
    if (!d) begin
        for (k = 0; k < 10 && sh !== 1'b1; k++) @(negedge clk);
        check(sh, 1);
    end
    if (h) begin
        settle(12);
        check(n_starts, ns);
        check(crun, 0);
        @(posedge clk);
        bcs_n <= 1;
    end
    for (k = 0; k < 20 && n_starts == ns; k++) @(negedge clk);
    check(busy, 1);
    check(oe_n, !d);
    if (d) check(pin_o, 1);
    @(posedge clk);
    {seq, pin, done} <= 3'b001;
    @(posedge clk);
    done <= 0;
    settle(1);
    check(busy, 0);
    if (d) check(pin_o, 0);
endtask
initial begin
    void'($urandom(9500));
    settle(7);
    check(oe_n, 1);
    check({irq_n, xreq}, 2'b10);
    @(posedge clk);
    rst <= 0;
    for (i = 0; i < 10; i++) do_op(i[0], i[1], i[2], i == 3 || i == 6, 3'($urandom), 3'($urandom));
    for (i = 0; i < 8; i++) begin
        @(posedge clk);
        {ack, en, ev, dly} <= {1'b0, 8'($urandom) | (8'h01 << i), 8'h01 << i, 4'($urandom % 8)};
        irq_q.push_back(8'h01 << i);
        @(posedge clk);
        ev <= 0;
        for (k = 0; k < 10 && irq_n !== 1'b0; k++) @(posedge clk);
        ack <= 1;
        for (k = 0; k < 30 && irq_n !== 1'b1; k++) @(posedge clk);
        @(negedge clk);
        check({irq_n, st}, 9'h100);
        @(posedge clk);
        {ack, en, ev} <= {1'b0, ~(8'h01 << i), 8'h01 << i};
        @(posedge clk);
        ev <= 0;
        settle(3);
        check({irq_n, st}, 9'h100);
    end
    for (i = 0; i < 4; i++) begin
        t = (i == 0) ? 1 : 1 + $urandom % 32;
        @(posedge clk);
        {thr, cnt} <= {6'(t), 6'(t - 1)};
        settle(3);
        check(xreq, 0);
        @(posedge clk);
        cnt <= 6'(t);
        settle(3);
        check(xreq, 1);
        @(posedge clk);
        cnt <= 6'((t > 1) ? t - 1 : 1);
        settle(3);
        check(xreq, 1);
        @(posedge clk);
        cnt <= 0;
        settle(3);
        check(xreq, 0);
    end
    @(posedge clk);
    thr <= 0;
    settle(3);
    check(xreq, 0);
    for (i = 0; i < 2; i++) begin
        @(posedge clk);
        {bw, rd} <= {i[0], 1'b1};
        settle(5);
        check(bmode, i[0]);
        check({lo_n, hi_n}, {1'b0, i[0]});
        @(posedge clk);
        rd <= 0;
        settle(2);
        check({lo_n, hi_n}, 2'b11);
    end
    end_of_test;
end
endmodule
`default_nettype wire
